//--- verilog/accel_ctrl_map.svh
// Behaviour
// - Registers are selected by a 7-bit address from the host.
// - Identity register at 0Fh is read-only and returns a fixed code.
// - Rate bit selects 100 Hz when zero, 400 Hz when one; reset zero.
// - Active-mode bit zero holds power-down; one enables measurement.
// - Range select bit, reset zero, chooses between two measurement ranges.
// - Two self-test bits, reset zero, apply output-shifting actuation when set.
// - Per-axis enables reset to one and gate data-ready generation per axis.
// - Three-wire select zero routes read data to serial out pin, else shared pin.
// - Trim values load from flash automatically after power-up reset.
// - Writing one to reload copies flash trims; bit self-clears when done.
// - Filtered output select routes filtered data to outputs when one.
// - Two bits enable the high-pass filter for event detector one and two.
// - Two-bit cut-off field, reset 00, picks cut-off scaled by data rate.
// - Interrupt polarity zero gives active-high pads, one active-low.
// - Driver bit zero drives pads push-pull, one open-drain.
// - Three-bit source per pad picks ground, events, data ready or click.
// - Reading the filter-zero address pulses a high-pass filter clear one clock later.
// - Six bits after direction and increment bits form the register address.
`ifndef ACCEL_CTRL_MAP_SVH
`define ACCEL_CTRL_MAP_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_IDENTITY    7'h0F
`define ADDR_MEASURE     7'h20
`define ADDR_IFFILTER    7'h21
`define ADDR_IRQPAD      7'h22
`define ADDR_FZERO       7'h23

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_MEASURE      8'h07
`define RST_IFFILTER     8'h00
`define RST_IRQPAD       8'h00
`define RST_CUTOFF       8'hC8

// ----------------------------------------
// Field positions and trim copy length
// ----------------------------------------
`define IFF_RELOAD_BIT   6
`define TRIM_LOAD_CYCLES 8

`endif

//--- verilog/accel_ctrl_pkg.sv
package accel_ctrl_pkg;

    typedef struct packed {
        logic       rateSelect;
        logic       activeModeBit;
        logic       rangeSelect;
        logic       selftestPlus;
        logic       selftestMinus;
        logic [2:0] axisEnable;
    } measure_t;

    typedef struct packed {
        logic       threeWireSelect;
        logic       reload;
        logic       unused;
        logic       filteredOutputSelect;
        logic       hpfOnDetectorTwo;
        logic       hpfOnDetectorOne;
        logic [1:0] cutoffSel;
    } iffilter_t;

    typedef struct packed {
        logic       irqPolarity;
        logic       irqDriverType;
        logic [2:0] pad2Source;
        logic [2:0] pad1Source;
    } irqpad_t;

    typedef struct packed {
        logic motionEventOne;
        logic motionEventTwo;
        logic dataReady;
        logic click;
    } events_t;

    typedef enum logic [2:0] {
        SRC_GND, SRC_EV1, SRC_EV2, SRC_EV12, SRC_DRDY, SRC_R5, SRC_R6,
        SRC_CLICK
    } pad_src_t;

    typedef enum { TRIM_IDLE, TRIM_COPY } trim_state_t;

endpackage

//--- verilog/accel_control_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "accel_ctrl_map.svh"

module accel_control_register_bank #(
    parameter logic [7:0] IDENTITY_CODE = 8'hA5, // Arbitrary value
    parameter int         TRIM_CYCLES   = `TRIM_LOAD_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     clkEn,
    // Register access from the serial engine
    input  wire logic [6:0]               regAddr,
    input  wire logic                     regWrStb,
    input  wire logic                     regRdStb,
    input  wire logic [7:0]               regWrData,
    output logic      [7:0]               regRdData,
    // Sensor chain controls
    output var accel_ctrl_pkg::measure_t  measureCtrl,
    output var accel_ctrl_pkg::iffilter_t filterCtrl,
    output logic      [7:0]               cutoffCentiHz,
    output logic                          hpfZeroPulse,
    output logic                          trimLoadActive,
    output logic                          threeWireMode,
    // Event sources
    input  wire accel_ctrl_pkg::events_t  events,
    // Interrupt pads: driven level and enable
    output logic                          irqPadOneOut,
    output logic                          irqPadOneOe,
    output logic                          irqPadTwoOut,
    output logic                          irqPadTwoOe
);
    import accel_ctrl_pkg::*;

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    measure_t  measure_ff;
    iffilter_t iff_ff;
    irqpad_t   irq_ff;
    logic [7:0] rdData_ff;
    logic       zero_ff;
    logic       pad1Out_ff;
    logic       pad1Oe_ff;
    logic       pad2Out_ff;
    logic       pad2Oe_ff;
    logic [7:0] cutoff_ff;
    trim_state_t trimState_ff;
    logic [7:0]  trimCnt_ff;
    logic        trimBusy_ff;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic hitMeasure = (regAddr == `ADDR_MEASURE);
    wire logic hitIff     = (regAddr == `ADDR_IFFILTER);
    wire logic hitIrq     = (regAddr == `ADDR_IRQPAD);
    wire logic hitZero    = (regAddr == `ADDR_FZERO);
    wire logic hitId      = (regAddr == `ADDR_IDENTITY);
    wire logic wrMeasure  = regWrStb && hitMeasure;
    wire logic wrIff      = regWrStb && hitIff;
    wire logic wrIrq      = regWrStb && hitIrq;
    wire logic rdZero     = regRdStb && hitZero;
    wire logic reloadReq  = wrIff && regWrData[`IFF_RELOAD_BIT];
    wire logic trimDone   = (trimState_ff == TRIM_COPY)
                         && (trimCnt_ff == 8'(TRIM_CYCLES - 1));

    // Identity never writable; unmapped reads give zero
    wire logic [7:0] rdMux =
        hitId      ? IDENTITY_CODE :
        hitMeasure ? measure_ff    :
        hitIff     ? iff_ff        :
        hitIrq     ? irq_ff        : 8'h00;

    // ----------------------------------------
    // Pad source selection
    // ----------------------------------------
    function automatic logic padSel(input logic [2:0] src,
                                    input events_t ev);
        case (pad_src_t'(src))
            SRC_EV1:   padSel = ev.motionEventOne;
            SRC_EV2:   padSel = ev.motionEventTwo;
            SRC_EV12:  padSel = ev.motionEventOne | ev.motionEventTwo;
            SRC_DRDY:  padSel = ev.dataReady;
            SRC_CLICK: padSel = ev.click;
            default:   padSel = 1'b0;
        endcase
    endfunction

    wire logic pad1Act = padSel(irq_ff.pad1Source, events);
    wire logic pad2Act = padSel(irq_ff.pad2Source, events);
    // Polarity flips the level; open-drain only pulls when asserted
    wire logic pad1Lvl = pad1Act ^ irq_ff.irqPolarity;
    wire logic pad2Lvl = pad2Act ^ irq_ff.irqPolarity;
    wire logic pad1En  = !irq_ff.irqDriverType || pad1Act;
    wire logic pad2En  = !irq_ff.irqDriverType || pad2Act;

    // Cut-off in hundredths of Hz: base at 100 Hz, four times at 400 Hz cut to 8 bits, field 00 at 400 Hz forced to FFh
    wire logic [7:0] cutBase = 8'hC8 >> iff_ff.cutoffSel;
    wire logic [7:0] nxt_cutoff = iff_ff.cutoffSel == 2'b00 &&
                                  measure_ff.rateSelect ? 8'hFF :
                                  (measure_ff.rateSelect ?
                                   8'(cutBase << 2) : cutBase);

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            measure_ff <= `RST_MEASURE;
            irq_ff     <= `RST_IRQPAD;
        end else if (clkEn) begin
            if (wrMeasure) begin
                measure_ff <= regWrData;
            end
            if (wrIrq) begin
                irq_ff <= regWrData;
            end
        end
    end

    // Reload bit self-clears when the copy completes; a new request wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            iff_ff <= `RST_IFFILTER;
        end else if (clkEn) begin
            if (wrIff) begin
                iff_ff <= regWrData;
            end else if (trimDone) begin
                iff_ff.reload <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Trim copy sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trimState_ff <= TRIM_COPY;
            trimCnt_ff   <= 8'h00;
            trimBusy_ff  <= 1'b1;
        end else if (clkEn) begin
            case (trimState_ff)
                TRIM_IDLE: begin
                    trimCnt_ff <= 8'h00;
                    if (reloadReq) begin
                        trimState_ff <= TRIM_COPY;
                        trimBusy_ff  <= 1'b1;
                    end
                end
                TRIM_COPY: begin
                    trimCnt_ff <= trimCnt_ff + 8'h01;
                    if (trimDone) begin
                        trimState_ff <= TRIM_IDLE;
                        trimBusy_ff  <= 1'b0;
                    end
                end
                default: begin
                    trimState_ff <= TRIM_IDLE;
                    trimBusy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_ff  <= 8'h00;
            zero_ff    <= 1'b0;
            pad1Out_ff <= 1'b0;
            pad1Oe_ff  <= 1'b1;
            pad2Out_ff <= 1'b0;
            pad2Oe_ff  <= 1'b1;
            cutoff_ff  <= `RST_CUTOFF;
        end else if (clkEn) begin
            rdData_ff  <= rdMux;
            zero_ff    <= rdZero;
            pad1Out_ff <= pad1Lvl;
            pad1Oe_ff  <= pad1En;
            pad2Out_ff <= pad2Lvl;
            pad2Oe_ff  <= pad2En;
            cutoff_ff  <= nxt_cutoff;
        end
    end

    assign regRdData      = rdData_ff;
    assign measureCtrl    = measure_ff;
    assign filterCtrl     = iff_ff;
    assign threeWireMode  = iff_ff.threeWireSelect;
    assign hpfZeroPulse   = zero_ff;
    assign trimLoadActive = trimBusy_ff;
    assign cutoffCentiHz  = cutoff_ff;
    assign irqPadOneOut   = pad1Out_ff;
    assign irqPadOneOe    = pad1Oe_ff;
    assign irqPadTwoOut   = pad2Out_ff;
    assign irqPadTwoOe    = pad2Oe_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    zero_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regRdStb && regAddr == `ADDR_FZERO |=> hpfZeroPulse)
        else $error("filter zero pulse missing");
    id_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regAddr == `ADDR_IDENTITY |=> regRdData == IDENTITY_CODE)
        else $error("identity read wrong");
    id_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_IDENTITY
        |=> $stable(measureCtrl) && $stable(filterCtrl))
        else $error("identity write disturbed state");
    measure_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_MEASURE
        |=> measureCtrl == $past(regWrData))
        else $error("measure control not written");
    reload_clear_a: assert property (@(posedge clk)
        disable iff (sys_rst)
        clkEn && trimDone && !wrIff |=> !filterCtrl.reload)
        else $error("reload bit stuck");
    reload_start_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !trimLoadActive && regWrStb && regAddr == `ADDR_IFFILTER
        && regWrData[`IFF_RELOAD_BIT] |=> trimLoadActive)
        else $error("reload copy not started");
    mode_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_IFFILTER
        |=> threeWireMode == $past(regWrData[7]))
        else $error("wire mode mismatch");
    pad_gnd_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.pad1Source inside {3'b000, 3'b101, 3'b110}
        && !irq_ff.irqPolarity |=> !irqPadOneOut)
        else $error("pad one not inactive");
    pad_pol_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.pad2Source == 3'b100 && events.dataReady
        |=> irqPadTwoOut == !$past(irq_ff.irqPolarity))
        else $error("pad two polarity wrong");
    pad_od_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.irqDriverType && !pad1Act |=> !irqPadOneOe)
        else $error("open drain drove idle pad");

    // ----------------------------------------
    // Checks: register writes and freeze
    // ----------------------------------------
    iff_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_IFFILTER
        |=> filterCtrl == $past(regWrData))
        else $error("filter control not written");

    irq_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_IRQPAD
        |=> irq_ff == $past(regWrData))
        else $error("pad control not written");

    measure_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !clkEn |=> $stable(measureCtrl))
        else $error("measure control moved while frozen");

    filter_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !clkEn |=> $stable(filterCtrl))
        else $error("filter control moved while frozen");

    irq_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !clkEn |=> $stable(irq_ff))
        else $error("pad control moved while frozen");

    measure_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !(regWrStb && regAddr == `ADDR_MEASURE)
        |=> $stable(measureCtrl))
        else $error("measure control changed unwritten");

    irq_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !(regWrStb && regAddr == `ADDR_IRQPAD)
        |=> $stable(irq_ff))
        else $error("pad control changed unwritten");

    zero_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regWrStb && regAddr == `ADDR_FZERO
        |=> $stable(measureCtrl) && $stable(irq_ff))
        else $error("strobe address write disturbed state");

    // ----------------------------------------
    // Checks: read path
    // ----------------------------------------
    meas_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regAddr == `ADDR_MEASURE
        |=> regRdData == $past(measureCtrl))
        else $error("measure read wrong");

    iff_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regAddr == `ADDR_IFFILTER
        |=> regRdData == $past(filterCtrl))
        else $error("filter read wrong");

    irq_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regAddr == `ADDR_IRQPAD
        |=> regRdData == $past(irq_ff))
        else $error("pad control read wrong");

    zero_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regAddr == `ADDR_FZERO |=> regRdData == 8'h00)
        else $error("strobe address read not zero");

    zero_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !(regRdStb && regAddr == `ADDR_FZERO) |=> !hpfZeroPulse)
        else $error("spurious filter zero pulse");

    read_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !clkEn |=> $stable(regRdData))
        else $error("read data moved while frozen");

    // ----------------------------------------
    // Checks: trim copy
    // ----------------------------------------
    trim_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && trimDone |=> !trimLoadActive)
        else $error("trim copy did not end");

    trim_count_a: assert property (@(posedge clk) disable iff (sys_rst)
        trimLoadActive |-> trimCnt_ff < 8'(TRIM_CYCLES))
        else $error("trim counter overran");

    trim_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && trimLoadActive && !trimDone |=> trimLoadActive)
        else $error("trim copy ended early");

    // ----------------------------------------
    // Checks: pads and cut-off
    // ----------------------------------------
    pad_od_two_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.irqDriverType && !pad2Act |=> !irqPadTwoOe)
        else $error("open drain drove idle pad two");

    pad_pp_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !irq_ff.irqDriverType |=> irqPadOneOe && irqPadTwoOe)
        else $error("push pull pad not driven");

    pad_or_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.pad1Source == 3'b011 && !irq_ff.irqPolarity
        && (events.motionEventOne || events.motionEventTwo)
        |=> irqPadOneOut)
        else $error("pad one event or missing");

    pad_click_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.pad2Source == 3'b111 && events.click
        && irq_ff.irqPolarity |=> !irqPadTwoOut)
        else $error("pad two click missing");

    pad_two_gnd_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && irq_ff.pad2Source inside {3'b000, 3'b101, 3'b110}
        && irq_ff.irqPolarity |=> irqPadTwoOut)
        else $error("pad two not inactive");

    cutoff_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !measure_ff.rateSelect && iff_ff.cutoffSel == 2'b00
        |=> cutoffCentiHz == `RST_CUTOFF)
        else $error("slow rate cut-off wrong");

endmodule
`default_nettype wire

//--- tb/accel_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module accel_host_model (
    // Clock
    input  wire logic       clk,
    // Register access
    output logic      [6:0] regAddr,
    output logic            regWrStb,
    output logic            regRdStb,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData
);
    initial begin
        regAddr   = 7'h00;
        regWrStb  = 1'b0;
        regRdStb  = 1'b0;
        regWrData = 8'h00;
    end

    // Six-bit serial field, zero-extended
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr   <= {1'b0, a};
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clk);
        regWrStb  <= 1'b0;
        regWrData <= ~d; // Stale data must not pass for valid
        #1;
    endtask

    task automatic rd(input logic [5:0] a, input logic s,
                      output logic [7:0] d);
        @(posedge clk);
        regAddr  <= {1'b0, a};
        regRdStb <= s;
        @(posedge clk);
        regRdStb <= 1'b0;
        #1;
        d = regRdData;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_accel_control_register_bank.sv
`timescale 1ns/10ps
`default_nettype none
module tb_accel_control_register_bank;
    import accel_ctrl_pkg::*;
    localparam logic [7:0] ID   = 8'h5A; // Arbitrary value
    localparam int         TRIM = 2;
    localparam logic [5:0] ADR [5] = '{6'h0F, 6'h20, 6'h21, 6'h22, 6'h10};
    localparam logic [7:0] RST [5] = '{ID, 8'h07, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] CUT [8] = '{8'hC8, 8'h64, 8'h32, 8'h19,
                                       8'hFF, 8'h90, 8'hC8, 8'h64};
    localparam events_t    PAT [3] = '{4'hA, 4'h5, 4'h0};
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       clkEn = 1'b1;
    logic [6:0] regAddr;
    logic       regWrStb, regRdStb, hpfZeroPulse, trimLoadActive;
    logic [7:0] regWrData, regRdData, cutoffCentiHz, rv, d;
    logic       threeWireMode, irqPadOneOut, irqPadOneOe;
    logic       irqPadTwoOut, irqPadTwoOe;
    measure_t   measureCtrl;
    iffilter_t  filterCtrl;
    events_t    ev = '0;
    int         fail_count = 0;
    int         num_checks = 0;

    always #10 clk = ~clk;

    accel_control_register_bank #(.IDENTITY_CODE(ID), .TRIM_CYCLES(TRIM))
    i_accel_control_register_bank (.clk(clk), .sys_rst(sys_rst),
        .clkEn(clkEn), .regAddr(regAddr), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regWrData(regWrData), .regRdData(regRdData),
        .measureCtrl(measureCtrl), .filterCtrl(filterCtrl),
        .cutoffCentiHz(cutoffCentiHz), .hpfZeroPulse(hpfZeroPulse),
        .trimLoadActive(trimLoadActive), .threeWireMode(threeWireMode),
        .events(ev), .irqPadOneOut(irqPadOneOut),
        .irqPadOneOe(irqPadOneOe), .irqPadTwoOut(irqPadTwoOut),
        .irqPadTwoOe(irqPadTwoOe));

    accel_host_model i_accel_host_model (.clk(clk), .regAddr(regAddr),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regWrData(regWrData),
        .regRdData(regRdData));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    function automatic logic padSrc(input logic [2:0] c, input events_t e);
        case (c)
            3'h1: return e.motionEventOne;
            3'h2: return e.motionEventTwo;
            3'h3: return e.motionEventOne | e.motionEventTwo;
            3'h4: return e.dataReady;
            3'h7: return e.click;
            default: return 1'b0;
        endcase
    endfunction

    // Open-drain level only matters while the pad drives
    task automatic padCheck(input string n, input logic o, input logic e,
                            input logic a, input logic pol, input logic od);
        check({n, " oe"}, {7'h0, e}, {7'h0, od ? a : 1'b1});
        if (!od || a) check({n, " level"}, {7'h0, o}, {7'h0, a ^ pol});
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check("trim at reset", {7'h0, trimLoadActive}, 8'h01);
        repeat (TRIM + 2) @(posedge clk);
        #1;
        check("trim done", {7'h0, trimLoadActive}, 8'h00);
        foreach (ADR[i]) begin
            i_accel_host_model.rd(ADR[i], 1'b0, rv);
            check("reset value", rv, RST[i]);
        end
        i_accel_host_model.wr(6'h0F, ~ID);
        i_accel_host_model.rd(6'h0F, 1'b0, rv);
        check("identity", rv, ID);
        for (int k = 0; k < 8; k++) begin
            d = {k[0], 2'b00, k[1], k[0], k[2], k[1:0]};
            i_accel_host_model.wr(6'h20, {k[2], k[0], k[1], k[0], k[1], 3'h5});
            check("measure", measureCtrl, {k[2], k[0], k[1], k[0], k[1], 3'h5});
            i_accel_host_model.wr(6'h21, d);
            check("filter", filterCtrl, d);
            check("three wire", {7'h0, threeWireMode}, {7'h0, k[0]});
            @(posedge clk);
            #1;
            check("cutoff", cutoffCentiHz, CUT[k]);
            i_accel_host_model.rd(6'h21, 1'b0, rv);
            check("filter read", rv, d);
        end
        i_accel_host_model.wr(6'h21, 8'h40);
        check("reload set", {7'h0, filterCtrl.reload}, 8'h01);
        check("reload busy", {7'h0, trimLoadActive}, 8'h01);
        repeat (TRIM + 2) @(posedge clk);
        #1;
        check("reload clear", {7'h0, filterCtrl.reload}, 8'h00);
        check("reload idle", {7'h0, trimLoadActive}, 8'h00);
        i_accel_host_model.rd(6'h23, 1'b1, rv);
        check("zero pulse", {7'h0, hpfZeroPulse}, 8'h01);
        @(posedge clk);
        #1;
        check("zero pulse end", {7'h0, hpfZeroPulse}, 8'h00);
        i_accel_host_model.rd(6'h20, 1'b1, rv);
        check("no zero pulse", {7'h0, hpfZeroPulse}, 8'h00);
        @(posedge clk) clkEn <= 1'b0;
        i_accel_host_model.wr(6'h20, 8'h00);
        check("frozen", measureCtrl, 8'hFD);
        @(posedge clk) clkEn <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int c = 0; c < 8; c++) begin
                foreach (PAT[p]) begin
                    i_accel_host_model.wr(6'h22, {m[1], m[0], ~c[2:0], c[2:0]});
                    @(posedge clk) ev <= PAT[p];
                    @(posedge clk);
                    #1;
                    padCheck("pad1", irqPadOneOut, irqPadOneOe,
                             padSrc(c[2:0], ev), m[1], m[0]);
                    padCheck("pad2", irqPadTwoOut, irqPadTwoOe,
                             padSrc(~c[2:0], ev), m[1], m[0]);
                end
            end
        end
        conclude();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire
